// file: shared/mfid_pkg.sv
// constants for the multifunction input decoder: codes, register map, defaults
// assumes a 250 MHz system clock and a classic wishbone slave with 32-bit data
package mfid_pkg;
   localparam int          NUM_IN       = 6;
   localparam int          SEL_W        = 8;
   localparam int          NUM_CTL      = 5;
   localparam int          NUM_IRQ      = 5;
   localparam int          ADR_W        = 8;

   // selector codes
   localparam logic [7:0]  CODE_MIN     = 8'h03;
   localparam logic [7:0]  CODE_MAX     = 8'h79;
   localparam logic [7:0]  CODE_STEP1   = 8'h03;
   localparam logic [7:0]  CODE_STEP3   = 8'h05;
   localparam logic [7:0]  CODE_RAMP1   = 8'h07;
   localparam logic [7:0]  CODE_BLK_NO  = 8'h08;
   localparam logic [7:0]  CODE_BLK_NC  = 8'h09;
   localparam logic [7:0]  CODE_THRU    = 8'h0F;
   localparam logic [7:0]  CODE_FRST    = 8'h14;
   localparam logic [7:0]  CODE_EST_NO  = 8'h15;
   localparam logic [7:0]  CODE_EST_NC  = 8'h17;
   localparam logic [7:0]  CODE_TIMER   = 8'h18;
   localparam logic [7:0]  CODE_RAMP2   = 8'h1A;
   localparam logic [3:0]  CODE_EF_HI   = 4'h2;
   localparam logic [7:0]  CODE_ELV_LO  = 8'h50;
   localparam logic [7:0]  CODE_ELV_HI  = 8'h58;
   localparam logic [7:0]  CODE_COMTST  = 8'h67;
   localparam logic [7:0]  CODE_BRAKE   = 8'h79;

   // external fault code fields (low nibble)
   localparam int          EF_NC_BIT    = 0;
   localparam int          EF_RUN_BIT   = 1;
   localparam int          EF_METH_LSB  = 2;
   localparam logic [1:0]  METH_RAMP    = 2'h0;
   localparam logic [1:0]  METH_COAST   = 2'h1;
   localparam logic [1:0]  METH_EMER    = 2'h2;
   localparam logic [1:0]  METH_ALARM   = 2'h3;

   // default selectors, terminal 3 in the low byte
   localparam logic [NUM_IN-1:0][SEL_W-1:0] DEF_SEL_A = {8'h0F, 8'h05, 8'h04, 8'h03, 8'h13, 8'h24};
   localparam logic [NUM_IN-1:0][SEL_W-1:0] DEF_SEL_B = {8'h0F, 8'h0F, 8'h53, 8'h51, 8'h54, 8'h50};
   localparam logic [1:0]  MODE_RST     = 2'h0;

   // register byte offsets
   localparam logic [7:0]  OFS_SEL0     = 8'h00;
   localparam logic [7:0]  OFS_CTRL     = 8'h18;
   localparam logic [7:0]  OFS_TERM     = 8'h1C;
   localparam logic [7:0]  OFS_STAT     = 8'h20;
   localparam logic [7:0]  OFS_IRQ      = 8'h24;
   localparam logic [7:0]  OFS_MASK     = 8'h28;
   localparam int          CTRL_LOAD    = 2;

   // interrupt status bits
   localparam int          IRQ_FAULT    = 0;
   localparam int          IRQ_ESTOP    = 1;
   localparam int          IRQ_BLOCK    = 2;
   localparam int          IRQ_ALARM    = 3;
   localparam int          IRQ_TERM     = 4;

   // block alarm blink half period
   localparam longint      CLK_PS       = 4000;
   localparam longint      FLASH_HALF_MS = 250;
   localparam longint      FLASH_HALF_CYC = (FLASH_HALF_MS * 1000000000) / CLK_PS;
endpackage : mfid_pkg

// file: design/mfid_decoder.sv
// multifunction input decoder: six selectable terminal functions with a wishbone register file
// assumes terminals and control pins are asynchronous to i_clk; host follows classic wishbone
`timescale 1ns/10ps

// Operation
// (RL1) six selectors, codes 3 through 79
// (RL2) terminals 3-7 defaults follow speed priority mode
// (RL3) eighth terminal defaults to pass-through
// (RL4) decode each documented code to its function
// (RL5) codes 3,4,5 form step speed index
// (RL6) code 7 picks ramp set one or two
// (RL7) blocking stops switching, flashes block alarm
// (RL8) code 8 blocks open, code 9 closed
// (RL9) controller applies brake before blocking output
// (RL10) pass-through does nothing, state stays readable
// (RL11) fault closes contact and shuts output off; the code sets output off only for coast-method faults
// (RL12) fault reset ignored while run command present
// (RL13) emergency stop decelerates on emergency ramp
// (RL14) no restart until stopped, released, unrun
// (RL15) code 15 closed active, 17 open active
// (RL16) overvoltage fault shuts output, motor coasts
// (RL17) external fault codes: polarity, scope, method
// (RL18) synchronise inputs; unknown codes act as pass-through
// (RL19) same function on several terminals is ORed
module mfid_decoder #(
   parameter int          NIN            = mfid_pkg::NUM_IN,
   parameter longint      FLASH_HALF_CYC = mfid_pkg::FLASH_HALF_CYC
) (
   // clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_nrst,
   // wishbone slave
   input  wire logic                       i_wb_cyc,
   input  wire logic                       i_wb_stb,
   input  wire logic                       i_wb_we,
   input  wire logic [mfid_pkg::ADR_W-1:0] i_wb_adr,
   input  wire logic [3:0]                 i_wb_sel,
   input  wire logic [31:0]                i_wb_dat,
   output logic      [31:0]                o_wb_dat,
   output logic                            o_wb_ack,
   output logic                            o_irq,
   // terminal pins, config_input_3 in bit 0
   input  wire logic [NIN-1:0]             i_config_input,
   // drive status pins
   input  wire logic                       i_run_up,
   input  wire logic                       i_run_down,
   input  wire logic                       i_motor_stopped,
   input  wire logic                       i_keypad_reset,
   input  wire logic                       i_overvoltage,
   // function outputs
   output logic      [2:0]                 o_step_index,
   output logic                            o_ramp_set2,
   output logic                            o_ramp_select2,
   output logic                            o_output_block,
   output logic                            o_output_block_alarm,
   output logic                            o_timer_input,
   output logic      [8:0]                 o_elevator_cmd,
   output logic                            o_comm_test,
   output logic                            o_brake_feedback,
   output logic                            o_fault_contact,
   output logic                            o_output_off,
   output logic                            o_ramp_stop,
   output logic                            o_emergency_decel,
   output logic                            o_run_inhibit,
   output logic                            o_ext_fault_alarm
);
   localparam logic [31:0] FLASH_TC = 32'(FLASH_HALF_CYC - 1);

   typedef struct packed {
      logic [NIN-1:0]                         sync1;
      logic [NIN-1:0]                         sync2;
      logic [mfid_pkg::NUM_CTL-1:0]           csync1;
      logic [mfid_pkg::NUM_CTL-1:0]           csync2;
      logic [NIN-1:0]                         term_prev;
      logic [NIN-1:0][mfid_pkg::SEL_W-1:0]    sel;
      logic [1:0]                             mode;
      logic [mfid_pkg::NUM_IRQ-1:0]           irq_stat;
      logic [mfid_pkg::NUM_IRQ-1:0]           irq_mask;
      logic                                   irq;
      logic                                   ack;
      logic [31:0]                            dat;
      logic                                   fault;
      logic [1:0]                             fault_meth;
      logic                                   estop_latch;
      logic [31:0]                            flash_cnt;
      logic                                   flash;
      logic [2:0]                             step;
      logic                                   ramp2;
      logic                                   ramp_sel2;
      logic                                   block;
      logic                                   timer_in;
      logic [8:0]                             elev;
      logic                                   comm_test;
      logic                                   brake_fb;
      logic                                   out_off;
      logic                                   ramp_stop;
      logic                                   emer_decel;
      logic                                   inhibit;
      logic                                   ext_alarm;
   } mfid_state_t;

   localparam mfid_state_t ST_RST = '{sel: mfid_pkg::DEF_SEL_A, mode: mfid_pkg::MODE_RST, default: '0};

   mfid_state_t st_ff;
   mfid_state_t nxt_st;

   // per-terminal function hits
   logic [NIN-1:0]       f_step0, f_step1, f_step2, f_ramp1, f_ramp2, f_blk, f_rst, f_est, f_tmr;
   logic [NIN-1:0]       f_ct, f_bf, f_ef_ramp, f_ef_coast, f_ef_emer, f_ef_alarm;
   logic [NIN-1:0][8:0]  f_elev;
   logic                 run_cmd;
   logic                 stopped;

   assign run_cmd = st_ff.csync2[0] | st_ff.csync2[1];
   assign stopped = st_ff.csync2[2];

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_term
         logic [7:0] code;
         logic       on;
         logic       ef_hit;
         logic       ef_act;
         assign code    = st_ff.sel[gi];
         assign on      = st_ff.sync2[gi];
         assign f_step0[gi] = (code == mfid_pkg::CODE_STEP1) & on;                       // see RL5
         assign f_step1[gi] = (code == mfid_pkg::CODE_STEP1 + 8'h01) & on;               // see RL5
         assign f_step2[gi] = (code == mfid_pkg::CODE_STEP3) & on;                       // see RL5
         assign f_ramp1[gi] = (code == mfid_pkg::CODE_RAMP1) & on;                       // see RL6
         assign f_ramp2[gi] = (code == mfid_pkg::CODE_RAMP2) & on;                       // see RL4
         assign f_blk[gi]   = ((code == mfid_pkg::CODE_BLK_NO) & ~on)                    // see RL8
                            | ((code == mfid_pkg::CODE_BLK_NC) & on);
         assign f_rst[gi]   = (code == mfid_pkg::CODE_FRST) & on;                        // see RL12
         assign f_est[gi]   = ((code == mfid_pkg::CODE_EST_NO) & on)                     // see RL15
                            | ((code == mfid_pkg::CODE_EST_NC) & ~on);
         assign f_tmr[gi]   = (code == mfid_pkg::CODE_TIMER) & on;                       // see RL4
         assign f_ct[gi]    = (code == mfid_pkg::CODE_COMTST) & on;                      // see RL4
         assign f_bf[gi]    = (code == mfid_pkg::CODE_BRAKE) & on;                       // see RL4
         // elevator commands 50..58 map to one bit each
         for (genvar ge = 0; ge < 9; ge++) begin : g_elev
            assign f_elev[gi][ge] = (code == mfid_pkg::CODE_ELV_LO + 8'(ge)) & on;       // see RL4
         end
         // low nibble: polarity, scope, stop method
         assign ef_hit = (code[7:4] == mfid_pkg::CODE_EF_HI);                            // see RL17
         assign ef_act = ef_hit & (on ^ code[mfid_pkg::EF_NC_BIT])
                       & (~code[mfid_pkg::EF_RUN_BIT] | run_cmd);
         assign f_ef_ramp[gi]  = ef_act & (code[3:2] == mfid_pkg::METH_RAMP);
         assign f_ef_coast[gi] = ef_act & (code[3:2] == mfid_pkg::METH_COAST);
         assign f_ef_emer[gi]  = ef_act & (code[3:2] == mfid_pkg::METH_EMER);
         assign f_ef_alarm[gi] = ef_act & (code[3:2] == mfid_pkg::METH_ALARM);
      end
   endgenerate

   // combined function levels; codes not listed hit nothing and pass through
   logic       est_act;
   logic       blk_act;
   logic       rst_req;
   logic       fault_req;
   logic [1:0] req_meth;
   logic       wb_req;
   logic       wb_wr;
   logic [8:0] elev_or;

   assign est_act = |f_est;                                                              // see RL19
   assign blk_act = |f_blk;                                                              // see RL19
   assign rst_req = (st_ff.csync2[3] | (|f_rst)) & ~run_cmd;                              // see RL12
   assign fault_req = (|f_ef_ramp) | (|f_ef_coast) | (|f_ef_emer) | st_ff.csync2[4];     // see RL11
   assign wb_req  = i_wb_cyc & i_wb_stb & ~st_ff.ack;
   assign wb_wr   = wb_req & i_wb_we & i_wb_sel[0];

   always_comb begin
      elev_or = '0;
      for (int k = 0; k < NIN; k++) begin
         elev_or = elev_or | f_elev[k];                                                 // see RL19
      end
   end

   // coast wins over emergency, emergency over ramp
   always_comb begin
      if (st_ff.csync2[4] | (|f_ef_coast)) begin
         req_meth = mfid_pkg::METH_COAST;                                               // see RL16
      end else if (|f_ef_emer) begin
         req_meth = mfid_pkg::METH_EMER;
      end else begin
         req_meth = mfid_pkg::METH_RAMP;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      // two-stage synchronisers
      nxt_st.sync1  = i_config_input;                                                    // see RL18
      nxt_st.sync2  = st_ff.sync1;
      nxt_st.csync1 = {i_overvoltage, i_keypad_reset, i_motor_stopped, i_run_down, i_run_up};
      nxt_st.csync2 = st_ff.csync1;
      nxt_st.term_prev = st_ff.sync2;

      // register writes
      nxt_st.ack = wb_req;
      if (wb_wr) begin
         if (i_wb_adr < mfid_pkg::OFS_CTRL) begin
            nxt_st.sel[i_wb_adr[4:2]] = i_wb_dat[7:0];                                    // see RL1
         end else if (i_wb_adr == mfid_pkg::OFS_CTRL) begin
            nxt_st.mode = i_wb_dat[1:0];
            if (i_wb_dat[mfid_pkg::CTRL_LOAD]) begin
               nxt_st.sel = (i_wb_dat[1:0] == 2'h1 || i_wb_dat[1:0] == 2'h2)             // see RL2
                          ? mfid_pkg::DEF_SEL_B : mfid_pkg::DEF_SEL_A;                    // see RL3
            end
         end else if (i_wb_adr == mfid_pkg::OFS_IRQ) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~i_wb_dat[mfid_pkg::NUM_IRQ-1:0];
         end else if (i_wb_adr == mfid_pkg::OFS_MASK) begin
            nxt_st.irq_mask = i_wb_dat[mfid_pkg::NUM_IRQ-1:0];
         end
      end

      // register reads
      nxt_st.dat = '0;
      if (wb_req & ~i_wb_we) begin
         case (i_wb_adr)
            mfid_pkg::OFS_CTRL: nxt_st.dat = {30'h0, st_ff.mode};
            mfid_pkg::OFS_TERM: nxt_st.dat = 32'(st_ff.sync2);                            // see RL10
            mfid_pkg::OFS_STAT: nxt_st.dat = {25'h0, st_ff.ext_alarm, st_ff.block, st_ff.inhibit,
                                              st_ff.estop_latch, st_ff.fault_meth, st_ff.fault};
            mfid_pkg::OFS_IRQ:  nxt_st.dat = 32'(st_ff.irq_stat);
            mfid_pkg::OFS_MASK: nxt_st.dat = 32'(st_ff.irq_mask);
            default: begin
               if (i_wb_adr < mfid_pkg::OFS_CTRL && i_wb_adr[1:0] == 2'h0) begin
                  nxt_st.dat = 32'(st_ff.sel[i_wb_adr[4:2]]);
               end
            end
         endcase
      end

      // fault latch, set wins over reset
      if (fault_req) begin
         nxt_st.fault = 1'b1;                                                            // see RL11
         if (!st_ff.fault || req_meth == mfid_pkg::METH_COAST) begin
            nxt_st.fault_meth = req_meth;                                                // see RL17
         end
      end else if (rst_req) begin
         nxt_st.fault = 1'b0;                                                            // see RL12
      end

      // emergency stop latch, cleared only when all three hold
      if (est_act & (run_cmd | ~stopped)) begin
         nxt_st.estop_latch = 1'b1;                                                      // see RL13
      end else if (stopped & ~est_act & ~run_cmd) begin
         nxt_st.estop_latch = 1'b0;                                                      // see RL14
      end

      // function outputs
      nxt_st.step      = {|f_step2, |f_step1, |f_step0};                                 // see RL5
      nxt_st.ramp2     = |f_ramp1;                                                       // see RL6
      nxt_st.ramp_sel2 = |f_ramp2;
      nxt_st.block     = blk_act;                                                        // see RL7
      nxt_st.timer_in  = |f_tmr;
      nxt_st.elev      = elev_or;
      nxt_st.comm_test = |f_ct;
      nxt_st.brake_fb  = |f_bf;
      nxt_st.ext_alarm = |f_ef_alarm;                                                    // see RL17
      nxt_st.out_off   = blk_act | (nxt_st.fault & nxt_st.fault_meth == mfid_pkg::METH_COAST); // see RL7
      nxt_st.ramp_stop = nxt_st.fault & nxt_st.fault_meth == mfid_pkg::METH_RAMP;
      nxt_st.emer_decel = ~nxt_st.out_off & ((nxt_st.fault & nxt_st.fault_meth == mfid_pkg::METH_EMER)
                        | (nxt_st.estop_latch & ~stopped));                              // see RL13
      nxt_st.inhibit   = nxt_st.fault | nxt_st.estop_latch;                              // see RL14

      // block alarm blinks while blocked
      if (!blk_act) begin
         nxt_st.flash_cnt = '0;
         nxt_st.flash     = 1'b0;
      end else if (!st_ff.block) begin
         nxt_st.flash_cnt = '0;
         nxt_st.flash     = 1'b1;                                                        // see RL7
      end else if (st_ff.flash_cnt == FLASH_TC) begin
         nxt_st.flash_cnt = '0;
         nxt_st.flash     = ~st_ff.flash;
      end else begin
         nxt_st.flash_cnt = st_ff.flash_cnt + 32'h1;
      end

      // sticky events, set wins over write-one-to-clear
      if (fault_req & ~st_ff.fault) nxt_st.irq_stat[mfid_pkg::IRQ_FAULT] = 1'b1;
      if (nxt_st.estop_latch & ~st_ff.estop_latch) nxt_st.irq_stat[mfid_pkg::IRQ_ESTOP] = 1'b1;
      if (blk_act & ~st_ff.block) nxt_st.irq_stat[mfid_pkg::IRQ_BLOCK] = 1'b1;
      if ((|f_ef_alarm) & ~st_ff.ext_alarm) nxt_st.irq_stat[mfid_pkg::IRQ_ALARM] = 1'b1;
      if (st_ff.sync2 != st_ff.term_prev) nxt_st.irq_stat[mfid_pkg::IRQ_TERM] = 1'b1;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_wb_dat             = st_ff.dat;
   assign o_wb_ack             = st_ff.ack;
   assign o_irq                = st_ff.irq;
   assign o_step_index         = st_ff.step;
   assign o_ramp_set2          = st_ff.ramp2;
   assign o_ramp_select2       = st_ff.ramp_sel2;
   assign o_output_block       = st_ff.block;
   assign o_output_block_alarm = st_ff.flash;
   assign o_timer_input        = st_ff.timer_in;
   assign o_elevator_cmd       = st_ff.elev;
   assign o_comm_test          = st_ff.comm_test;
   assign o_brake_feedback     = st_ff.brake_fb;
   assign o_fault_contact      = st_ff.fault;
   assign o_output_off         = st_ff.out_off;
   assign o_ramp_stop          = st_ff.ramp_stop;
   assign o_emergency_decel    = st_ff.emer_decel;
   assign o_run_inhibit        = st_ff.inhibit;
   assign o_ext_fault_alarm    = st_ff.ext_alarm;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sync_delay_a: assert property (st_ff.sync2 == $past(i_config_input, 2)) // see RL18
      else $error("terminal synchroniser depth wrong");
   step_bit_a: assert property (st_ff.sel[0] == mfid_pkg::CODE_STEP1 && st_ff.sync2[0] |=> o_step_index[0]) // see RL5
      else $error("step index bit not set");
   ramp_set_a: assert property (st_ff.sel[1] == mfid_pkg::CODE_RAMP1 |=> o_ramp_set2 == $past(st_ff.sync2[1])) // see RL6
      else $error("ramp set does not follow terminal");
   block_open_a: assert property (st_ff.sel[0] == mfid_pkg::CODE_BLK_NO && !st_ff.sync2[0] |=> o_output_block) // see RL8
      else $error("normally open block not applied");
   block_closed_a: assert property (st_ff.sel[0] == mfid_pkg::CODE_BLK_NC && st_ff.sync2[0] |=> o_output_block) // see RL8
      else $error("normally closed block not applied");
   block_coast_a: assert property ($rose(o_output_block) |-> o_output_off && o_output_block_alarm) // see RL7
      else $error("block without coast or alarm");
   thru_idle_a: assert property (st_ff.sel == {NIN{mfid_pkg::CODE_THRU}} |=> !o_output_block && o_step_index == 3'h0 && !o_timer_input) // see RL10
      else $error("pass-through triggered a function");
   ov_coast_a: assert property (st_ff.csync2[4] |=> o_fault_contact && o_output_off) // see RL16
      else $error("overvoltage did not coast");
   reset_hold_a: assert property (o_fault_contact && run_cmd && !fault_req |=> o_fault_contact) // see RL12
      else $error("fault reset taken during run");
   estop_decel_a: assert property (est_act && !stopped && !blk_act && !st_ff.fault && !fault_req |=> o_emergency_decel) // see RL13
      else $error("emergency stop did not decelerate");
   estop_hold_a: assert property (o_run_inhibit && !o_fault_contact && (run_cmd || est_act) && !fault_req |=> o_run_inhibit) // see RL14
      else $error("restart allowed too early");
   estop_nc_a: assert property (st_ff.sel[2] == mfid_pkg::CODE_EST_NC && !st_ff.sync2[2] && run_cmd |=> o_run_inhibit) // see RL15
      else $error("normally closed emergency stop missed");
   ext_coast_a: assert property (st_ff.sel[3] == 8'h24 && st_ff.sync2[3] ##1 1'b1 |-> o_fault_contact && o_output_off) // see RL17
      else $error("external coast fault missed");
   default_b_a: assert property (wb_wr && i_wb_adr == mfid_pkg::OFS_CTRL && i_wb_dat[2:0] == 3'h5 |=> st_ff.sel[0] == 8'h50 && st_ff.sel[5] == mfid_pkg::CODE_THRU) // see RL2
      else $error("mode defaults not loaded");
   ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");
endmodule : mfid_decoder

// file: testbench/mfid_contacts.sv
// switch contacts wired to the six terminals; the bench sets the wanted levels
// assumes the bench changes i_want only just after a rising edge of i_clk
`timescale 1ns/10ps
module mfid_contacts (
   // clock
   input  wire logic       i_clk,
   // wanted contact levels
   input  wire logic [5:0] i_want,
   // terminal pins
   output logic      [5:0] o_pins
);
   // contacts move one edge later; each pin takes its wanted level at the next rising edge
   always_ff @(posedge i_clk) begin
      o_pins <= i_want;
   end
endmodule : mfid_contacts

// file: testbench/tb_top.sv
// randomised bench for the input decoder: defaults, step index, block, emergency stop, irq
// assumes a classic wishbone slave answering one edge after the taking edge
`timescale 1ns/10ps
module tb_top;
   logic i_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, run = 1'b0, stp = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [5:0]  want = 6'h00, pins, w;
   logic [2:0]  step;
   logic        ack, irq, blk, off, edec, inh;
   logic        rdn = 1'b0, kr = 1'b0, ov = 1'b0, rs2, rsel2, tmr, ct, bf, flt, rstp, efa, alm;
   logic [8:0]  elev;
   logic [7:0]  cd;
   logic [3:0]  nb;
   int          n;
   logic [7:0]  ctab [6] = '{8'h07, 8'h1A, 8'h18, 8'h67, 8'h79, 8'h13};
   int          error_cnt = 0, check_count = 0;
   logic [7:0]  dtab [2][6] = '{'{8'h24, 8'h13, 8'h03, 8'h04, 8'h05, 8'h0F},
                                '{8'h50, 8'h54, 8'h51, 8'h53, 8'h0F, 8'h0F}};
   always #2 i_clk = ~i_clk;
   mfid_contacts sw (.i_clk(i_clk), .i_want(want), .o_pins(pins));
   mfid_decoder #(.FLASH_HALF_CYC(4)) dut (.i_clk(i_clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .o_irq(irq), .i_config_input(pins), .i_run_up(run), .i_run_down(rdn), .i_motor_stopped(stp),
      .i_keypad_reset(kr), .i_overvoltage(ov), .o_step_index(step), .o_ramp_set2(rs2), .o_ramp_select2(rsel2),
      .o_output_block(blk), .o_output_block_alarm(alm), .o_timer_input(tmr), .o_elevator_cmd(elev),
      .o_comm_test(ct), .o_brake_feedback(bf), .o_fault_contact(flt), .o_output_off(off), .o_ramp_stop(rstp),
      .o_emergency_decel(edec), .o_run_inhibit(inh), .o_ext_fault_alarm(efa));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // levels {ramp set 2, ramp select 2, timer, elevator[8:0], comm test, brake} for a closed terminal
   function automatic logic [13:0] exp_fn(input logic [7:0] c);
      exp_fn = 14'h0;
      case (c)
         8'h07: exp_fn[13] = 1'b1;
         8'h1A: exp_fn[12] = 1'b1;
         8'h18: exp_fn[11] = 1'b1;
         8'h67: exp_fn[1] = 1'b1;
         8'h79: exp_fn[0] = 1'b1;
         default: if (c >= 8'h50 && c <= 8'h58) exp_fn[4'(c - 8'h4E)] = 1'b1;
      endcase
   endfunction : exp_fn
   // {fault, output off, ramp stop, emergency decel, alarm} for an active external fault, no run command
   function automatic logic [4:0] exp_ef(input logic [3:0] x);
      logic act;
      act = ~x[1];
      exp_ef = {act & x[3:2] != 2'h3, act & x[3:2] == 2'h1, act & x[3:2] == 2'h0, act & x[3:2] == 2'h2,
                act & x[3:2] == 2'h3};
   endfunction : exp_ef
   task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= wr;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do @(posedge i_clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      @(posedge i_clk);
   endtask : wb
   task automatic settle;
      repeat (5) @(posedge i_clk);
   endtask : settle
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h4bfe));
      repeat (20) @(posedge i_clk);
      nrst <= 1'b1;
      @(posedge i_clk);
      // pass 0 is the reset state, then modes 0..3 loaded through the control word
      for (int p = 0; p < 5; p++) begin
         if (p > 0) wb(1'b1, 8'h18, 32'(p + 3));
         for (int i = 0; i < 6; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, {24'h0, dtab[(p == 2 || p == 3) ? 1 : 0][i]});
         end
      end
      wb(1'b1, 8'h40, $urandom);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 6; i++) wb(1'b1, 8'(4 * i), (i < 3) ? 32'(3 + i) : 32'h0F);
      for (int k = 0; k < 12; k++) begin
         w = (k == 0) ? 6'h3F : 6'($urandom);
         want <= w;
         settle();
         chk({blk, step}, {1'b0, w[2:0]});
         wb(1'b0, 8'h1C, 32'h0);
         chk(rd, {26'h0, w});
      end
      for (int c = 0; c < 2; c++) begin
         wb(1'b1, 8'h00, 32'(8 + c));
         for (int l = 0; l < 2; l++) begin
            want <= 6'(l);
            settle();
            chk({blk, off, irq}, {{2{l[0] ~^ c[0]}}, 1'b0});
            n = 0;
            repeat (8) begin
               @(posedge i_clk);
               n += alm;
            end
            chk(n, (l[0] ~^ c[0]) ? 32'h4 : 32'h0);
         end
      end
      wb(1'b1, 8'h28, 32'h4);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b1);
      wb(1'b1, 8'h24, 32'h4);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b0);
      wb(1'b1, 8'h00, 32'h0F);
      for (int c = 0; c < 2; c++) begin
         // contact takes its released level at the edge that arms the code, before run is raised
         want <= 6'(c << 2);
         wb(1'b1, 8'h08, c ? 32'h17 : 32'h15);
         run <= 1'b1;
         stp <= 1'b0;
         settle();
         chk({edec, inh}, 2'b00);
         want <= 6'((1 - c) << 2);
         settle();
         chk({edec, inh}, 2'b11);
         want <= 6'(c << 2);
         settle();
         chk(inh, 1'b1);
         run <= 1'b0;
         stp <= 1'b1;
         settle();
         chk({edec, inh}, 2'b00);
      end
      for (int i = 0; i < 6; i++) wb(1'b1, 8'(4 * i), 32'h0F);
      w = 6'($urandom);
      want <= w;
      settle();
      chk({blk, step, inh}, 5'h00);
      wb(1'b0, 8'h1C, 32'h0);
      chk(rd, {26'h0, w});
      for (int k = 0; k < 8; k++) begin
         cd = (k < 6) ? ctab[k] : 8'(8'h50 + $urandom_range(8));
         wb(1'b1, 8'h04, 32'(cd));
         want <= 6'h02;
         settle();
         chk({rs2, rsel2, tmr, elev, ct, bf}, exp_fn(cd));
         want <= 6'h00;
         settle();
         chk({rs2, rsel2, tmr, elev, ct, bf}, 14'h0);
      end
      ov <= 1'b1;
      settle();
      chk({flt, off}, 2'b11);
      ov <= 1'b0;
      rdn <= 1'b1;
      kr <= 1'b1;
      settle();
      chk(flt, 1'b1);
      rdn <= 1'b0;
      settle();
      chk({flt, off}, 2'b00);
      for (int k = 0; k < 6; k++) begin
         nb = (k == 0) ? 4'h4 : 4'($urandom);
         kr <= 1'b0;
         wb(1'b1, 8'h0C, {24'h0, 4'h2, nb});
         want <= nb[0] ? 6'h00 : 6'h08;
         settle();
         chk({flt, off, rstp, edec, efa}, exp_ef(nb));
         want <= nb[0] ? 6'h08 : 6'h00;
         kr <= 1'b1;
         settle();
         chk({flt, off, rstp, edec, efa}, 5'h00);
      end
      tally_and_finish();
   end
endmodule : tb_top
